// ===== verilog/itm_pkg.sv
// constants for the instruction execution time model
// How it works
// - stop-on-address mode adds 7.8 us to every instruction
// - address-generating instructions add an addressing extra time to base time
// - register/storage extra: mode 00 2.0, 01 2.6, 10 2.6/3.2, 11 3.2/6.2 us
// - storage/storage extra from sixteen-entry table, 3.6 us up to 8.8 us
// - first mode 11, second mode 00/01, first base field 00: add 0.2 us
// - storage/storage: add 1.6 us per operand with mode 11 and nonzero base
// - first operand mode is first table index, second operand mode second index
// - flagged instructions take 0.6 us longer when mode field is 01
// - flagged count instructions take 5.4 us total when start count is zero
// - byte-field compare takes 8.4 us plus 7.8 us per element of start count
// - interruptible instructions let an interrupt end execution partway
// - word compare with odd second operand address takes 7.8 us
// - i/o operate takes 9.1/9.7 us minimum, 28.9/29.5 us maximum
package itm_pkg;
  // times are kept in units of 0.1 us
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CYC_PER_TENTH = CLK_MHZ / 10;
  localparam logic [11:0] T_STOP_ADDR = 12'd78;
  localparam logic [11:0] T_AM01_ADJ = 12'd6;
  localparam logic [11:0] T_ZERO_CNT = 12'd54;
  localparam logic [11:0] T_CMP_BASE = 12'd84;
  localparam logic [11:0] T_CMP_ELEM = 12'd78;
  localparam logic [11:0] T_ODD_CW = 12'd78;
  localparam logic [11:0] T_RB1_ADD = 12'd2;
  localparam logic [11:0] T_RB_ADD = 12'd16;
  localparam logic [11:0] T_IO_MIN = 12'd91;
  localparam logic [11:0] T_IO_MIN_IND = 12'd97;
  localparam logic [11:0] T_IO_MAX = 12'd289;
  localparam logic [11:0] T_IO_MAX_IND = 12'd295;
  localparam logic [11:0] T_RS_00 = 12'd20;
  localparam logic [11:0] T_RS_01 = 12'd26;
  localparam logic [11:0] T_RS_10Z = 12'd26;
  localparam logic [11:0] T_RS_10N = 12'd32;
  localparam logic [11:0] T_RS_11Z = 12'd32;
  localparam logic [11:0] T_RS_11N = 12'd62;
  localparam logic [15:0][11:0] T_SS_TABLE = {
    12'd88, 12'd80, 12'd68, 12'd62,
    12'd80, 12'd72, 12'd60, 12'd54,
    12'd68, 12'd60, 12'd48, 12'd42,
    12'd62, 12'd54, 12'd42, 12'd36};
  typedef enum logic [1:0] {ITM_PLAIN, ITM_REGSTORE, ITM_STORSTORE, ITM_IOOP} itm_class_type;
  typedef enum logic [1:0] {ITM_NORMAL, ITM_ZERO_NOTE, ITM_FIELD_CMP, ITM_ODD_CW} itm_kind_type;
endpackage

// ===== verilog/itm_addr_extra.sv
// addressing-mode extra time for one instruction
`timescale 1ns/1ps
module itm_addr_extra
(
  input  wire logic [1:0]  i_addr_mode_field,
  input  wire logic [1:0]  i_base_reg_field,
  input  wire logic [1:0]  i_second_operand_mode,
  input  wire logic [1:0]  i_second_base_field,
  input  wire logic        i_storstore,
  output logic      [11:0] o_extra
);
  logic [11:0] regstore_extra_time;
  logic [11:0] ss_time;
  logic [11:0] ss_rb1;
  logic [11:0] ss_rb_1;
  logic [11:0] ss_rb_2;
  logic        rb_zero;
  logic [3:0]  ss_idx;
  assign rb_zero = (i_base_reg_field == 2'h0);
  assign regstore_extra_time = (i_addr_mode_field == 2'h0) ? itm_pkg::T_RS_00 :
                               (i_addr_mode_field == 2'h1) ? itm_pkg::T_RS_01 :
                               (i_addr_mode_field == 2'h2) ? (rb_zero ? itm_pkg::T_RS_10Z : itm_pkg::T_RS_10N) :
                               (rb_zero ? itm_pkg::T_RS_11Z : itm_pkg::T_RS_11N);
  assign ss_idx  = {i_addr_mode_field, i_second_operand_mode};
  assign ss_time = itm_pkg::T_SS_TABLE[ss_idx];
  assign ss_rb1  = (i_addr_mode_field == 2'h3 && !i_second_operand_mode[1] && rb_zero)
                   ? itm_pkg::T_RB1_ADD : 12'h0;
  assign ss_rb_1 = (i_addr_mode_field == 2'h3 && !rb_zero) ? itm_pkg::T_RB_ADD : 12'h0;
  assign ss_rb_2 = (i_second_operand_mode == 2'h3 && i_second_base_field != 2'h0) ? itm_pkg::T_RB_ADD : 12'h0;
  assign o_extra = i_storstore ? (ss_time + ss_rb1 + ss_rb_1 + ss_rb_2) : regstore_extra_time;
endmodule

// ===== verilog/itm_time_model.sv
// instruction execution time model: cycle count per instruction
`timescale 1ns/1ps
module itm_time_model
#(
  parameter int unsigned CNT_W = 16
)
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_ce,
  input  wire logic                 i_start,
  input  wire itm_pkg::itm_class_type i_class,
  input  wire itm_pkg::itm_kind_type  i_kind,
  input  wire logic [11:0]          i_base_time,
  input  wire logic [1:0]           i_addr_mode_field,
  input  wire logic [1:0]           i_base_reg_field,
  input  wire logic [1:0]           i_second_operand_mode,
  input  wire logic [1:0]           i_second_base_field,
  input  wire logic                 i_am01_adj,
  input  wire logic                 i_stop_on_addr,
  input  wire logic [CNT_W-1:0]     i_start_count,
  input  wire logic [11:0]          i_count_elem_time,
  input  wire logic                 i_odd_operand2,
  input  wire logic                 i_io_indirect,
  input  wire logic [11:0]          i_io_device_delay,
  input  wire logic                 i_interruptible,
  input  wire logic                 i_irq,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_interrupted,
  output logic [31:0]               o_total_cycles
);
  // ----------------------------------------------------------------
  // time sum
  // ----------------------------------------------------------------
  logic [11:0] addr_extra;
  logic [31:0] base_sum;
  logic [31:0] cnt_sum;
  logic [31:0] io_sum;
  logic [31:0] tenth_sum;
  logic [31:0] nxt_cycles;
  logic [11:0] io_min;
  logic [11:0] io_max;
  logic        uses_addr;

  itm_addr_extra u_extra
  (
    .i_addr_mode_field     (i_addr_mode_field),
    .i_base_reg_field      (i_base_reg_field),
    .i_second_operand_mode (i_second_operand_mode),
    .i_second_base_field   (i_second_base_field),
    .i_storstore           (i_class == itm_pkg::ITM_STORSTORE),
    .o_extra               (addr_extra)
  );

  assign uses_addr = (i_class == itm_pkg::ITM_REGSTORE) || (i_class == itm_pkg::ITM_STORSTORE);
  assign base_sum  = {20'h0, i_base_time} + (uses_addr ? {20'h0, addr_extra} : 32'h0)
                   + ((i_am01_adj && i_addr_mode_field == 2'h1) ? {20'h0, itm_pkg::T_AM01_ADJ} : 32'h0);
  // element time is a port so the move and scan field forms share one path
  assign cnt_sum   = (i_kind == itm_pkg::ITM_FIELD_CMP)
                   ? {20'h0, itm_pkg::T_CMP_BASE} + 32'(i_start_count) * 32'(itm_pkg::T_CMP_ELEM)
                   : base_sum + 32'(i_start_count) * {20'h0, i_count_elem_time};
  assign io_min    = i_io_indirect ? itm_pkg::T_IO_MIN_IND : itm_pkg::T_IO_MIN;
  assign io_max    = i_io_indirect ? itm_pkg::T_IO_MAX_IND : itm_pkg::T_IO_MAX;
  // device delay stretches the minimum but never past the documented maximum
  assign io_sum    = ({20'h0, io_min} + {20'h0, i_io_device_delay} > {20'h0, io_max})
                   ? {20'h0, io_max} : {20'h0, io_min} + {20'h0, i_io_device_delay};
  always_comb
  begin
    if (i_class == itm_pkg::ITM_IOOP)
      tenth_sum = io_sum;
    else if (i_kind == itm_pkg::ITM_ZERO_NOTE && i_start_count == '0)
      tenth_sum = {20'h0, itm_pkg::T_ZERO_CNT};
    else if (i_kind == itm_pkg::ITM_ODD_CW && i_odd_operand2)
      tenth_sum = {20'h0, itm_pkg::T_ODD_CW};
    else if (i_kind == itm_pkg::ITM_FIELD_CMP || i_kind == itm_pkg::ITM_ZERO_NOTE)
      tenth_sum = cnt_sum;
    else
      tenth_sum = base_sum;
    if (i_stop_on_addr)
      tenth_sum = tenth_sum + {20'h0, itm_pkg::T_STOP_ADDR};
  end
  assign nxt_cycles = tenth_sum * itm_pkg::CYC_PER_TENTH;

  // ----------------------------------------------------------------
  // execution countdown
  // ----------------------------------------------------------------
  logic [31:0] remain_ff;
  logic        busy_ff;
  logic        done_ff;
  logic        intr_ff;
  logic        intr_ok_ff;
  logic [31:0] total_ff;
  logic        take_irq;
  assign take_irq = busy_ff && intr_ok_ff && i_irq;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      remain_ff  <= 32'h0;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      intr_ff    <= 1'b0;
      intr_ok_ff <= 1'b0;
      total_ff   <= 32'h0;
    end
    else if (i_ce)
    begin
      done_ff <= 1'b0;
      intr_ff <= 1'b0;
      if (!busy_ff && i_start)
      begin
        total_ff   <= nxt_cycles;
        remain_ff  <= nxt_cycles;
        busy_ff    <= (nxt_cycles != 32'h0);
        done_ff    <= (nxt_cycles == 32'h0);
        intr_ok_ff <= i_interruptible;
      end
      else if (take_irq)
      begin
        busy_ff <= 1'b0;
        intr_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        remain_ff <= remain_ff - 32'h1;
        if (remain_ff == 32'h1)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
  assign o_busy         = busy_ff;
  assign o_done         = done_ff;
  assign o_interrupted  = intr_ff;
  assign o_total_cycles = total_ff;
endmodule

// ===== verif/itm_time_model_properties.sv
// assertion checker for the instruction time model
`timescale 1ns/1ps
module itm_time_model_chk
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire logic        i_start,
  input wire logic        i_stop_on_addr,
  input wire logic        i_interruptible,
  input wire logic        i_irq,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_interrupted,
  input wire logic [31:0] o_total_cycles
);
  // ----------------
  // checks
  // ----------------
  logic [31:0] busy_len_ff;
  wire         tk = i_ce && i_start && !o_busy;
  wire         irq_ok = i_irq && i_interruptible && o_busy;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // counts busy cycles so the reported total can be held against them
  always_ff @(posedge i_mclk)
    if (!i_nrst) busy_len_ff <= 32'h0;
    else if (i_ce) busy_len_ff <= o_busy ? busy_len_ff + 32'h1 : 32'h0;
  chk_start_answer: assert property (tk |=> o_busy || o_done) else $error("start ignored");
  chk_busy_length: assert property (o_done |-> busy_len_ff == o_total_cycles) else $error("busy length off");
  chk_total_holds: assert property (o_busy |=> $stable(o_total_cycles)) else $error("total moved");
  chk_done_idle: assert property (o_done |-> !o_busy && !o_interrupted) else $error("done while busy");
  chk_irq_abort: assert property (i_ce && irq_ok |=> !o_busy && o_interrupted) else $error("irq lost");
  chk_irq_cause: assert property (o_interrupted |-> $past(irq_ok)) else $error("stray interrupt");
  chk_irq_single: assert property (o_interrupted && i_ce |=> !o_interrupted) else $error("long pulse");
  chk_stop_extra: assert property (tk && i_stop_on_addr |=> o_total_cycles >= 32'h9c) else $error("no stop add");
  cov_done: cover property (o_done);
  cov_irq: cover property (o_interrupted);
  cov_stop: cover property (tk && i_stop_on_addr);
endmodule
bind itm_time_model itm_time_model_chk u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_start(i_start),
  .i_stop_on_addr(i_stop_on_addr), .i_interruptible(i_interruptible), .i_irq(i_irq), .o_busy(o_busy),
  .o_done(o_done), .o_interrupted(o_interrupted), .o_total_cycles(o_total_cycles));

// ===== verif/test_itm_time_model.sv
// self-checking bench for the instruction time model
`timescale 1ns/1ps
module test_itm_time_model;
  logic                   ck = 1'h0, rn, ce, st, aj, so, od, ii, ir, rq, bz, dn, it;
  logic [1:0]             am, rb, m2, r2;
  logic [11:0]            bt, et, dl;
  logic [15:0]            ct;
  logic [31:0]            tot;
  itm_pkg::itm_class_type cl;
  itm_pkg::itm_kind_type  kd;
  int                     fails = 0, cmp_count = 0;
  itm_time_model u_itm_time_model (.i_mclk(ck), .i_nrst(rn), .i_ce(ce), .i_start(st), .i_class(cl), .i_kind(kd),
    .i_base_time(bt), .i_addr_mode_field(am), .i_base_reg_field(rb), .i_second_operand_mode(m2),
    .i_second_base_field(r2), .i_am01_adj(aj), .i_stop_on_addr(so), .i_start_count(ct), .i_count_elem_time(et),
    .i_odd_operand2(od), .i_io_indirect(ii), .i_io_device_delay(dl), .i_interruptible(ir), .i_irq(rq),
    .o_busy(bz), .o_done(dn), .o_interrupted(it), .o_total_cycles(tot));
  initial forever #25 ck = ~ck;
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  // one instruction: total in 0.1 us units becomes two clocks each
  task automatic run(input itm_pkg::itm_class_type c, input itm_pkg::itm_kind_type k, input logic [11:0] b,
                     input logic [7:0] f, input int e);
    int n = 0;
    @(posedge ck);
    cl <= c;
    kd <= k;
    bt <= b;
    {am, rb, m2, r2} <= f;
    st <= 1'h1;
    @(posedge ck);
    st <= 1'h0;
    #1 cmp(tot, 32'(2 * e));
    while (dn !== 1'h1 && n < 3000)
    begin
      @(posedge ck);
      #1 n++;
    end
    cmp(32'(n), 32'(2 * e));
  endtask
  task automatic t_rs();
    logic [11:0] rs [8] = '{12'h14, 12'h14, 12'h1a, 12'h1a, 12'h1a, 12'h20, 12'h20, 12'h3e};
    aj <= 1'h1;
    for (int i = 0; i < 8; i++)
      run(itm_pkg::ITM_REGSTORE, itm_pkg::ITM_NORMAL, 12'h32, {i[2:1], 1'h0, i[0], 4'h0},
          12'h32 + rs[i] + (i[2:1] == 2'h1 ? 12'h6 : 12'h0));
    aj <= 1'h0;
    $display("t_rs end");
  endtask
  task automatic t_ss();
    logic [19:0] x [4] = '{20'hc0072, 20'hc4078, 20'h0c070, 20'hd0080};
    for (int i = 0; i < 16; i++)
      run(itm_pkg::ITM_STORSTORE, itm_pkg::ITM_NORMAL, 12'h32, {i[3:2], 2'h1, i[1:0], 2'h2}, 12'h32 +
          itm_pkg::T_SS_TABLE[i] + (i[3:2] == 2'h3 ? 12'h10 : 12'h0) + (i[1:0] == 2'h3 ? 12'h10 : 12'h0));
    for (int i = 0; i < 4; i++)
      run(itm_pkg::ITM_STORSTORE, itm_pkg::ITM_NORMAL, 12'h32, x[i][19:12], x[i][11:0]);
    $display("t_ss end");
  endtask
  task automatic t_kinds();
    ct <= 16'h0;
    run(itm_pkg::ITM_PLAIN, itm_pkg::ITM_ZERO_NOTE, 12'h54, 8'h0, 12'h36);
    ct <= 16'h3;
    run(itm_pkg::ITM_PLAIN, itm_pkg::ITM_FIELD_CMP, 12'h0, 8'h0, 12'h13e);
    od <= 1'h1;
    run(itm_pkg::ITM_PLAIN, itm_pkg::ITM_ODD_CW, 12'h3a, 8'h0, 12'h4e);
    run(itm_pkg::ITM_IOOP, itm_pkg::ITM_NORMAL, 12'h0, 8'h0, 12'h5b);
    ii <= 1'h1;
    dl <= 12'hfff;
    run(itm_pkg::ITM_IOOP, itm_pkg::ITM_NORMAL, 12'h0, 8'h0, 12'h127);
    so <= 1'h1;
    run(itm_pkg::ITM_PLAIN, itm_pkg::ITM_NORMAL, 12'h2a, 8'h0, 12'h78);
    so <= 1'h0;
    $display("t_kinds end");
  endtask
  // a low enable must hold the countdown where it stands
  task automatic t_ce();
    int n = 0;
    @(posedge ck);
    cl <= itm_pkg::ITM_PLAIN;
    kd <= itm_pkg::ITM_NORMAL;
    bt <= 12'h5;
    st <= 1'h1;
    @(posedge ck);
    st <= 1'h0;
    ce <= 1'h0;
    repeat (10) @(posedge ck);
    ce <= 1'h1;
    #1 cmp(32'({bz, dn}), 32'h2);
    while (dn !== 1'h1 && n < 100)
    begin
      @(posedge ck);
      #1 n++;
    end
    cmp(32'(n), 32'ha);
    $display("t_ce end");
  endtask
  // starts held high while busy must be refused, then the irq cuts it short
  task automatic t_irq();
    ir <= 1'h1;
    ct <= 16'h5;
    cl <= itm_pkg::ITM_PLAIN;
    kd <= itm_pkg::ITM_FIELD_CMP;
    @(posedge ck);
    st <= 1'h1;
    @(posedge ck);
    kd <= itm_pkg::ITM_ODD_CW;
    repeat (8) @(posedge ck);
    st <= 1'h0;
    rq <= 1'h1;
    #1 cmp(tot, 32'h3b4);
    @(posedge ck);
    rq <= 1'h0;
    #1 cmp(32'({bz, it}), 32'h1);
    $display("t_irq end");
  endtask
  initial
  begin
    repeat (20000) @(posedge ck);
    fails++;
    end_of_test();
  end
  initial
  begin
    {rn, ce, st, aj, so, od, ii, ir, rq} = 9'h080;
    {am, rb, m2, r2, bt, et, dl, ct} = '0;
    cl = itm_pkg::ITM_PLAIN;
    kd = itm_pkg::ITM_NORMAL;
    repeat (12) @(posedge ck);
    rn <= 1'h1;
    #1 cmp(32'({bz, dn, it}), 32'h0);
    cmp(tot, 32'h0);
    t_rs();
    t_ss();
    t_kinds();
    t_ce();
    t_irq();
    end_of_test();
  end
endmodule
